// *** hdl/lce_cell_group.sv ***
// Group of eight logic cells with APB configuration port
//
// Register access over APB and the register offsets were decided locally.
module lce_cell_group (
    input wire logic clk_sys_i, // 200 MHz system clock
    input wire logic reset_n_i, // Async reset, active low
    // APB slave
    input wire logic psel_i, // Slave select
    input wire logic penable_i, // Access phase
    input wire logic pwrite_i, // Write when high
    input wire logic [lce_pkg::ADDR_W-1:0] paddr_i, // Byte address
    input wire logic [31:0] pwdata_i, // Write data
    output logic [31:0] prdata_o, // Read data, registered
    output logic pready_o, // Always ready
    output logic pslverr_o, // Unmapped or illegal access
    // Cell fabric
    input lce_pkg::lce_data_t [lce_pkg::CELLS-1:0] cell_data_i, // Local data per cell
    input wire logic cell_clear_i, // Group clear, active high
    input wire logic cell_preset_i, // Group preset, active high
    input wire logic carry_in_i, // Chain entry
    input wire logic cascade_in_i, // Chain entry
    output logic carry_out_o, // Chain exit
    output logic cascade_out_o, // Chain exit
    output logic [lce_pkg::CELLS-1:0] local_out_o, // Local interconnect outputs
    output logic [lce_pkg::CELLS-1:0] global_out_o // Global routing outputs
);

    localparam int N = lce_pkg::CELLS; // Cells in the group
    localparam int IDX_W = $clog2(lce_pkg::CELLS); // Cell index width

    // ==========================================================
    // Declarations
    logic [31:0] cfg_word_q [N]; // Raw configuration words
    lce_pkg::lce_cfg_t cfg [N]; // Decoded configuration
    logic [N:0] carry_chain; // Carry between cells
    logic [N:0] cascade_chain; // Cascade between cells
    logic [N-1:0] reg_q; // Flop outputs
    logic [N-1:0] lut_val; // Table outputs after cascade
    logic [N-1:0] reg_d; // Flop data
    logic [N-1:0] reg_en; // Flop enables
    logic apb_setup; // First cycle of a transfer
    logic apb_access; // Completing cycle of a transfer
    logic cfg_hit; // Address inside configuration words
    logic stat_hit; // Address is the status word
    logic aligned; // Word-aligned address
    logic [IDX_W-1:0] cfg_idx; // Addressed cell
    logic [31:0] status_word; // Live state for reads
    logic [31:0] rd_mux; // Read data before the register

    // ==========================================================
    // APB decode
    // Zero wait states: pready is constant, so every access phase
    // completes at its first edge. Read data is caught at the setup
    // edge, which lets prdata come from a flop without a wait state.
    assign apb_setup = psel_i & ~penable_i;
    assign apb_access = psel_i & penable_i;
    assign aligned = (paddr_i[1:0] == 2'h0);
    assign cfg_hit = aligned && (paddr_i < lce_pkg::STATUS_OFS);
    assign stat_hit = (paddr_i == lce_pkg::STATUS_OFS);
    assign cfg_idx = IDX_W'((paddr_i - lce_pkg::CFG_BASE_OFS) >> 2);
    assign pready_o = 1'b1;
    // Writes to status and anything unmapped report an error
    assign pslverr_o = apb_access & ~(cfg_hit | (stat_hit & ~pwrite_i));

    // ==========================================================
    // Status word
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[lce_pkg::STAT_REG_LSB +: N] = reg_q;
        status_word[lce_pkg::STAT_LUT_LSB +: N] = lut_val;
        status_word[lce_pkg::STAT_COUT_BIT] = carry_chain[N];
        status_word[lce_pkg::STAT_CASC_BIT] = cascade_chain[N];
    end

    // Read mux, zero on unmapped addresses
    always_comb begin
        if (cfg_hit) begin
            rd_mux = cfg_word_q[cfg_idx];
        end else if (stat_hit) begin
            rd_mux = status_word;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // Read data register; status may be one cycle old at completion
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (apb_setup && !pwrite_i) begin
            prdata_o <= rd_mux;
        end
    end

    // ==========================================================
    // Chain ends
    assign carry_chain[0] = carry_in_i;
    assign cascade_chain[0] = cascade_in_i;
    assign carry_out_o = carry_chain[N];
    assign cascade_out_o = cascade_chain[N];

    // ==========================================================
    // Cells
    // All cells share the group clock, clear and preset, as they
    // share one local interconnect; chains run from cell 0 upward.
    for (genvar i = 0; i < N; i++) begin : g_cell
        // Configuration word, written at the completing APB edge
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                cfg_word_q[i] <= lce_pkg::CFG_RESET;
            end else if (apb_access && pwrite_i && cfg_hit && cfg_idx == IDX_W'(i)) begin
                cfg_word_q[i] <= pwdata_i;
            end
        end

        assign cfg[i] = lce_pkg::cfg_decode(cfg_word_q[i]);

        // Table, chains and output routing
        lce_cell_comb u_comb (
            .cfg_i(cfg[i]),
            .data_i(cell_data_i[i]),
            .fb_i(reg_q[i]),
            .carry_in_i(carry_chain[i]),
            .cascade_in_i(cascade_chain[i]),
            .lut_o(lut_val[i]),
            .carry_out_o(carry_chain[i+1]),
            .cascade_out_o(cascade_chain[i+1]),
            .reg_d_o(reg_d[i]),
            .reg_en_o(reg_en[i]),
            .local_o(local_out_o[i]),
            .global_o(global_out_o[i])
        );

        // Cell flop with its three control inputs
        lce_cell_reg u_reg (
            .clk_sys_i(clk_sys_i),
            .reset_n_i(reset_n_i),
            .clear_i(cell_clear_i),
            .preset_i(cell_preset_i),
            .enable_i(reg_en[i]),
            .d_i(reg_d[i]),
            .q_o(reg_q[i])
        );
    end

    // ==========================================================
    // Assertions on cell 0 and the bus
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // Helpers for cell 0
    logic quiet; // No clear or preset
    logic normal0; // Cell 0 in normal mode
    assign quiet = !cell_clear_i && !cell_preset_i;
    assign normal0 = (cfg[0].mode == lce_pkg::MODE_NORMAL);

    a_apb_ready: assert property (
        apb_access |-> pready_o) else $error("APB access not completed");

    a_cfg_write: assert property (
        (apb_access && pwrite_i && paddr_i == lce_pkg::CFG_BASE_OFS)
        |=> cfg_word_q[0] == $past(pwdata_i)) else $error("Config write lost");

    a_status_read: assert property (
        (apb_setup && !pwrite_i && stat_hit) ##1 apb_access
        |-> prdata_o[lce_pkg::STAT_REG_LSB +: N] == $past(reg_q)) else $error("Status read wrong");

    a_enable_hold: assert property (
        (cfg[0].ena_sel && !cell_data_i[0].data_in_first && quiet) ##1 quiet
        |-> $stable(reg_q[0])) else $error("Flop moved while disabled");

    a_normal_table: assert property (
        (normal0 && !cfg[0].casc_en && !cfg[0].pack && cfg[0].cin_sel)
        |-> lut_val[0] == cfg[0].lut_mask[{cell_data_i[0].data_in_fourth, carry_in_i,
            cell_data_i[0].data_in_second, cell_data_i[0].data_in_first}])
        else $error("Normal table lookup wrong");

    a_cascade_and: assert property (
        (normal0 && cfg[0].casc_en && !cascade_in_i) |-> !cascade_chain[1])
        else $error("Cascade-in low did not block");

    a_unpacked_same: assert property (
        (!cfg[0].pack || !normal0) |-> (local_out_o[0] == global_out_o[0]) &&
        (global_out_o[0] == (cfg[0].out_reg ? reg_q[0] : lut_val[0])))
        else $error("Unpacked outputs differ");

    a_packed_load: assert property (
        (normal0 && cfg[0].pack && !cfg[0].ena_sel && quiet) ##1 quiet
        |-> reg_q[0] == $past(cell_data_i[0].data_in_fourth)) else $error("Packed flop missed data");

    a_packed_split: assert property (
        (normal0 && cfg[0].pack) |-> (global_out_o[0] == (cfg[0].pack_swap ? lut_val[0] : reg_q[0]))
        && (local_out_o[0] == (cfg[0].pack_swap ? reg_q[0] : lut_val[0])))
        else $error("Packed routing wrong");

    a_pack_lut3: assert property (
        (normal0 && cfg[0].pack && cfg[0].pack_lut3 && !cfg[0].casc_en && cfg[0].cin_sel)
        |-> lut_val[0] == cfg[0].lut_mask[{1'b0, carry_in_i,
            cell_data_i[0].data_in_second, cell_data_i[0].data_in_first}])
        else $error("Packed table used fourth input");

    // Main scenarios
    c_clear_and_preset: cover property (cell_clear_i && cell_preset_i);
    c_packed_cell: cover property (normal0 && cfg[0].pack ##1 reg_q[0] != $past(reg_q[0]));
    c_cascade_pass: cover property (cfg[0].casc_en && cascade_chain[1]);
    c_arith_carry: cover property (cfg[0].mode == lce_pkg::MODE_ARITH && carry_chain[1]);

endmodule : lce_cell_group

// *** shared/lce_pkg.sv ***
// Constants and carrier types for the logic cell group
//
// Contract
// - Cell holds table, flop, carry, cascade paths
// - Eight cells share one local interconnect
// - Four modes: normal, arithmetic, two counters
// - Seven logic inputs including feedback, chains
// - Flop has clock, clear, preset controls
// - First data input may gate flop enable
// - Normal table uses inputs one, two, four
// - Cascade-in combines with table into cascade-out
// - Separate local and global outputs per cell
// - Unpacked: flop or table drives both outputs
// - Packed: fourth input loads flop directly
// - Alt packing: four-input table, input shared
// - Packed flop keeps enable, clear, preset
// - Packed: configuration assigns outputs to routes
// - Clear and preset act without a clock; a preset that outlasts clear is only stored at the next edge
package lce_pkg;

    // ==========================================================
    // Group shape
    localparam int CELLS = 8; // Cells in one group
    localparam int LUT_BITS = 16; // Four-input table contents
    localparam int MODE_W = 4; // One-hot mode field width
    localparam int ADDR_W = 8; // APB address width used

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [ADDR_W-1:0] CFG_BASE_OFS = 8'h00; // Cell n at base plus 4n
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h20; // Read-only live state
    localparam logic [31:0] CFG_RESET = 32'h0001_0000; // Normal mode, all off

    // ==========================================================
    // Configuration word fields
    localparam int LUT_LSB = 0; // Table contents
    localparam int MODE_LSB = 16; // Operating mode
    localparam int CIN_SEL_BIT = 20; // Carry-in replaces third input
    localparam int CASC_EN_BIT = 21; // Join the cascade chain
    localparam int ENA_SEL_BIT = 22; // First input is clock enable
    localparam int PACK_BIT = 23; // Register packing
    localparam int PACK_LUT3_BIT = 24; // Packed table ignores fourth input
    localparam int OUT_REG_BIT = 25; // Unpacked: flop drives outputs
    localparam int PACK_SWAP_BIT = 26; // Packed: table goes global

    // ==========================================================
    // Status word fields
    localparam int STAT_REG_LSB = 0; // Flop outputs
    localparam int STAT_LUT_LSB = 8; // Table outputs after cascade
    localparam int STAT_COUT_BIT = 16; // Group carry-out
    localparam int STAT_CASC_BIT = 17; // Group cascade-out

    // ==========================================================
    // Types
    typedef enum logic [MODE_W-1:0] {
        MODE_NORMAL = 4'h1,
        MODE_ARITH = 4'h2,
        MODE_UPDN = 4'h4,
        MODE_CLRCNT = 4'h8
    } lce_mode_t;

    typedef struct packed {
        logic data_in_fourth; // Fourth data input
        logic data_in_third; // Third data input
        logic data_in_second; // Second data input
        logic data_in_first; // First data input
    } lce_data_t;

    typedef struct packed {
        logic pack_swap; // Packed output routing
        logic out_reg; // Unpacked output source
        logic pack_lut3; // Three-input packed table
        logic pack; // Packing on
        logic ena_sel; // Enable from first input
        logic casc_en; // Cascade on
        logic cin_sel; // Carry-in into table
        lce_mode_t mode; // Operating mode
        logic [LUT_BITS-1:0] lut_mask; // Table contents
    } lce_cfg_t;

    // Unpacks a configuration word by the field positions above
    function automatic lce_cfg_t cfg_decode(input logic [31:0] w);
        lce_cfg_t c;
        c.lut_mask = w[LUT_LSB +: LUT_BITS];
        c.mode = lce_mode_t'(w[MODE_LSB +: MODE_W]);
        c.cin_sel = w[CIN_SEL_BIT];
        c.casc_en = w[CASC_EN_BIT];
        c.ena_sel = w[ENA_SEL_BIT];
        c.pack = w[PACK_BIT];
        c.pack_lut3 = w[PACK_LUT3_BIT];
        c.out_reg = w[OUT_REG_BIT];
        c.pack_swap = w[PACK_SWAP_BIT];
        return c;
    endfunction : cfg_decode

endpackage : lce_pkg

// *** hdl/lce_cell_reg.sv ***
// Programmable cell flip-flop with enable, clear and preset
module lce_cell_reg (
    input wire logic clk_sys_i, // Cell clock
    input wire logic reset_n_i, // Global reset, active low
    input wire logic clear_i, // Async clear, active high
    input wire logic preset_i, // Async preset, active high
    input wire logic enable_i, // Synchronous clock enable
    input wire logic d_i, // Data to store
    output logic q_o // Stored value
);

    logic store_q; // Value held between edges

    // ==========================================================
    // Storage
    // Clear and preset are in the sensitivity list so they force
    // the value without waiting for an edge; both load constants.
    always_ff @(posedge clk_sys_i or negedge reset_n_i or posedge clear_i or posedge preset_i) begin
        if (!reset_n_i) begin
            store_q <= 1'b0;
        end else if (clear_i) begin
            store_q <= 1'b0;
        end else if (preset_i) begin
            store_q <= 1'b1;
        end else if (enable_i) begin
            store_q <= d_i;
        end
    end

    // Output override: the edge list cannot see clear falling while
    // preset stays high, so preset also forces the output directly.
    // Limitation: a preset dropped before the next edge in that case
    // leaves the stored zero showing.
    assign q_o = clear_i ? 1'b0 : (preset_i ? 1'b1 : store_q);

    // ==========================================================
    // Checks
    a_clear_holds_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        clear_i |-> !q_o) else $error("Clear did not force zero");
    a_preset_forces_one: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (preset_i && !clear_i) |-> q_o) else $error("Preset did not force one");

endmodule : lce_cell_reg

// *** hdl/lce_cell_comb.sv ***
// Look-up table, chain paths and output routing of one cell
module lce_cell_comb (
    input lce_pkg::lce_cfg_t cfg_i, // Cell configuration
    input lce_pkg::lce_data_t data_i, // Four local data inputs
    input wire logic fb_i, // Own flop output
    input wire logic carry_in_i, // From previous cell
    input wire logic cascade_in_i, // From previous cell
    output logic lut_o, // Table value after cascade
    output logic carry_out_o, // To next cell
    output logic cascade_out_o, // To next cell
    output logic reg_d_o, // Flop data
    output logic reg_en_o, // Flop enable
    output logic local_o, // To local interconnect
    output logic global_o // To row and column routing
);

    logic lut_raw; // Table before cascade
    logic pack_on; // Packing only exists in normal mode
    logic sel_in; // Carry-in or third input
    logic fourth; // Fourth table input, maskable

    // ==========================================================
    // Table and carry per mode
    always_comb begin
        sel_in = cfg_i.cin_sel ? carry_in_i : data_i.data_in_third;
        fourth = data_i.data_in_fourth & ~(cfg_i.pack & cfg_i.pack_lut3);
        pack_on = 1'b0;
        lut_raw = 1'b0;
        carry_out_o = carry_in_i;
        reg_d_o = 1'b0;
        unique case (cfg_i.mode)
            lce_pkg::MODE_ARITH: begin
                // Low half makes the sum, high half the carry
                lut_raw = cfg_i.lut_mask[{1'b0, carry_in_i, data_i.data_in_second, data_i.data_in_first}];
                carry_out_o = cfg_i.lut_mask[{1'b1, carry_in_i, data_i.data_in_second, data_i.data_in_first}];
            end
            lce_pkg::MODE_UPDN, lce_pkg::MODE_CLRCNT: begin
                // Feedback replaces the first input; second is direction
                lut_raw = cfg_i.lut_mask[{1'b0, carry_in_i, data_i.data_in_second, fb_i}];
                carry_out_o = cfg_i.lut_mask[{1'b1, carry_in_i, data_i.data_in_second, fb_i}];
            end
            default: begin
                // Normal mode, also taken for illegal mode codes
                lut_raw = cfg_i.lut_mask[{fourth, sel_in, data_i.data_in_second, data_i.data_in_first}];
                pack_on = cfg_i.pack;
            end
        endcase
        lut_o = cfg_i.casc_en ? (lut_raw & cascade_in_i) : lut_raw;
        cascade_out_o = lut_o;
        // Counter loads: third input loads fourth, or clears
        if (cfg_i.mode == lce_pkg::MODE_UPDN && data_i.data_in_third) begin
            reg_d_o = data_i.data_in_fourth;
        end else if (cfg_i.mode == lce_pkg::MODE_CLRCNT && data_i.data_in_third) begin
            reg_d_o = 1'b0;
        end else if (pack_on) begin
            reg_d_o = data_i.data_in_fourth;
        end else begin
            reg_d_o = lut_o;
        end
    end

    // ==========================================================
    // Enable and outputs
    assign reg_en_o = cfg_i.ena_sel ? data_i.data_in_first : 1'b1;

    always_comb begin
        if (pack_on) begin
            global_o = cfg_i.pack_swap ? lut_o : fb_i;
            local_o = cfg_i.pack_swap ? fb_i : lut_o;
        end else begin
            global_o = cfg_i.out_reg ? fb_i : lut_o;
            local_o = global_o;
        end
    end

endmodule : lce_cell_comb

// *** verif/lce_nbr_model.sv ***
// Model of the neighbouring cells that feed the group's chain entries
module lce_nbr_model (
    input wire logic clk_sys_i, // System clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic carry_req_i, // Carry the previous cell should produce
    input wire logic cascade_req_i, // Cascade the previous cell should produce
    output logic carry_o, // Carry into cell 0
    output logic cascade_o // Cascade into cell 0
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Previous cell outputs come from its own flop, so they move one edge late
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            carry_o <= 1'b0; // Chains idle low
            cascade_o <= 1'b0;
        end else begin
            carry_o <= carry_req_i;
            cascade_o <= cascade_req_i;
        end
    end
endmodule : lce_nbr_model

// *** verif/tb.sv ***
// Self-checking bench for the eight-cell group
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i, cell_clear_i, cell_preset_i;
    logic [lce_pkg::ADDR_W-1:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic pready_o, pslverr_o, carry_in_i, cascade_in_i, carry_out_o, cascade_out_o, err, car_q, cas_q;
    lce_pkg::lce_data_t [lce_pkg::CELLS-1:0] cell_data_i;
    logic [lce_pkg::CELLS-1:0] local_out_o, global_out_o;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    localparam logic [31:0] NRM = lce_pkg::CFG_RESET; // Normal mode, empty table
    // ==========================================================
    // Design and its neighbours
    lce_cell_group DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .cell_data_i(cell_data_i), .cell_clear_i(cell_clear_i),
        .cell_preset_i(cell_preset_i), .carry_in_i(carry_in_i), .cascade_in_i(cascade_in_i),
        .carry_out_o(carry_out_o), .cascade_out_o(cascade_out_o), .local_out_o(local_out_o),
        .global_out_o(global_out_o));
    lce_nbr_model NBR (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .carry_req_i(car_q),
        .cascade_req_i(cas_q), .carry_o(carry_in_i), .cascade_o(cascade_in_i));
    // ==========================================================
    // Clock and watchdog; the whole run needs well under a thousand cycles
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++; // Hang counts as a mismatch
            close_out();
        end
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] bw(input int b);
        return 32'h1 << b;
    endfunction : bw
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit
    // One APB transfer; idle cycle first so no signal is driven twice in a step
    // Waits for pready with no limit of its own: the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // Drive cell 0 data and chain request, then look just after the next edge
    task automatic step(input logic [3:0] d, input logic c);
        @(posedge clk_sys_i);
        cell_data_i[0] <= d;
        car_q <= c;
        @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic outs(input logic l, input logic g);
        chk_bit("local_out", l, local_out_o[0]);
        chk_bit("global_out", g, global_out_o[0]);
    endtask : outs
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        apb(1'b0, 8'h1c, 32'h0);
        chk_word("cfg7 reset", NRM, rd);
        apb(1'b0, lce_pkg::STATUS_OFS, 32'h0);
        chk_word("status reset", 32'h0, rd);
        apb(1'b1, lce_pkg::STATUS_OFS, 32'hffff_ffff);
        chk_bit("status write err", 1'b1, err);
        apb(1'b0, 8'h24, 32'h0);
        chk_bit("unmapped err", 1'b1, err);
        chk_word("unmapped data", 32'h0, rd);
        apb(1'b1, 8'h04, NRM | 32'h1234);
        apb(1'b0, 8'h04, 32'h0);
        chk_word("cfg1 readback", NRM | 32'h1234, rd);
        $display("test regs done");
    endtask : t_regs
    task automatic t_lut();
        apb(1'b1, 8'h00, NRM | 32'h8000);
        step(4'hf, 1'b1);
        outs(1'b1, 1'b1);
        chk_bit("carry_out", 1'b1, carry_out_o);
        step(4'h7, 1'b0);
        outs(1'b0, 1'b0);
        chk_bit("carry_out", 1'b0, carry_out_o);
        apb(1'b1, 8'h00, NRM | 32'h8000 | bw(lce_pkg::CIN_SEL_BIT));
        step(4'hb, 1'b1);
        outs(1'b1, 1'b1);
        step(4'hf, 1'b0);
        outs(1'b0, 1'b0);
        $display("test lut done");
    endtask : t_lut
    task automatic t_reg();
        apb(1'b1, 8'h00, NRM | 32'hffff | bw(lce_pkg::ENA_SEL_BIT) | bw(lce_pkg::OUT_REG_BIT));
        step(4'h0, 1'b0);
        outs(1'b1, 1'b1);
        // Clear and preset act without waiting for an edge; the check falls between edges
        @(posedge clk_sys_i);
        cell_clear_i <= 1'b1;
        #1;
        outs(1'b0, 1'b0);
        @(posedge clk_sys_i);
        cell_clear_i <= 1'b0;
        step(4'h0, 1'b0);
        outs(1'b0, 1'b0);
        step(4'h1, 1'b0);
        outs(1'b1, 1'b1);
        apb(1'b0, lce_pkg::STATUS_OFS, 32'h0);
        chk_bit("status q0", 1'b1, rd[lce_pkg::STAT_REG_LSB]);
        step(4'h0, 1'b0);
        outs(1'b1, 1'b1);
        @(posedge clk_sys_i);
        cell_clear_i <= 1'b1;
        cell_preset_i <= 1'b1;
        #1;
        outs(1'b0, 1'b0);
        @(posedge clk_sys_i);
        cell_clear_i <= 1'b0;
        #1;
        outs(1'b1, 1'b1);
        @(posedge clk_sys_i);
        cell_preset_i <= 1'b0;
        $display("test register done");
    endtask : t_reg
    task automatic t_pack();
        apb(1'b1, 8'h00, NRM | 32'h0080 | bw(lce_pkg::PACK_BIT) | bw(lce_pkg::PACK_LUT3_BIT));
        step(4'h8, 1'b0);
        outs(1'b0, 1'b1);
        step(4'hf, 1'b0);
        outs(1'b1, 1'b1);
        apb(1'b1, 8'h00, NRM | 32'h0080 | bw(lce_pkg::PACK_BIT) | bw(lce_pkg::PACK_LUT3_BIT)
            | bw(lce_pkg::PACK_SWAP_BIT));
        step(4'h7, 1'b0);
        outs(1'b0, 1'b1);
        @(posedge clk_sys_i);
        cell_preset_i <= 1'b1;
        #1;
        outs(1'b1, 1'b1);
        @(posedge clk_sys_i);
        cell_preset_i <= 1'b0;
        apb(1'b1, 8'h00, NRM | 32'h8000 | bw(lce_pkg::PACK_BIT));
        step(4'hf, 1'b0);
        outs(1'b1, 1'b1);
        step(4'h7, 1'b0);
        outs(1'b0, 1'b0);
        $display("test packing done");
    endtask : t_pack
    task automatic t_casc();
        for (int i = 0; i < lce_pkg::CELLS; i++) begin
            apb(1'b1, 8'(4 * i), NRM | 32'hffff | bw(lce_pkg::CASC_EN_BIT));
        end
        cas_q <= 1'b1;
        step(4'h0, 1'b0);
        chk_bit("cascade_out", 1'b1, cascade_out_o);
        cas_q <= 1'b0;
        step(4'h0, 1'b0);
        chk_bit("cascade_out", 1'b0, cascade_out_o);
        apb(1'b1, 8'h0c, NRM | bw(lce_pkg::CASC_EN_BIT));
        cas_q <= 1'b1;
        step(4'h0, 1'b0);
        chk_bit("cascade_out", 1'b0, cascade_out_o);
        $display("test cascade done");
    endtask : t_casc
    // Arithmetic mode: low half of the mask is the sum, high half the carry
    task automatic t_arith();
        apb(1'b1, 8'h00, (32'(lce_pkg::MODE_ARITH) << lce_pkg::MODE_LSB) | 32'he896);
        step(4'h3, 1'b1);
        outs(1'b1, 1'b1);
        chk_bit("carry_out", 1'b1, carry_out_o);
        step(4'h2, 1'b0);
        outs(1'b1, 1'b1);
        chk_bit("carry_out", 1'b0, carry_out_o);
        $display("test arithmetic done");
    endtask : t_arith
    // ==========================================================
    // Verdict and main sequence
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    initial begin
        reset_n_i = 1'b0;
        {psel_i, penable_i, pwrite_i, cell_clear_i, cell_preset_i, car_q, cas_q} = '0;
        paddr_i = '0;
        pwdata_i = '0;
        cell_data_i = '0;
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_lut();
        t_reg();
        t_pack();
        t_casc();
        t_arith();
        close_out();
    end
endmodule : tb
